// ==== verilog/touch_cfg.svh ====
/*
  Constants of the touch controller serial port: register addresses,
  command codes, pass code, factory values and stretch timing.
  Assumes a single system clock of the period given below.
*/
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// =====================================================================
// register addresses
`define REG_CS_ENABLE    8'h07
`define REG_DIG_ENABLE   8'h08
`define REG_STRONG_DM    8'h11
`define REG_SETL_TIME    8'h50
`define REG_OTH_SET      8'h51
`define REG_SCAN_POS_0   8'h5c
`define REG_SCAN_POS_1   8'h5d
`define REG_ADDR_LOCK    8'h79
`define REG_DEVICE_ID    8'h7a
`define REG_SLAVE_ADDR   8'h7c
`define REG_COMMAND      8'ha0

// =====================================================================
// command codes, pass code and factory values
`define CMD_SCAN_OFF     8'h0a
`define CMD_SCAN_ON      8'h0b
`define PASS_CODE        8'h5a
`define DEF_ADDR_LOCK    8'h01

// =====================================================================
// stretch timing: least processing time, rounded up to whole cycles
`define CLK_PERIOD_NS    10
`define HOLD_NORM_NS     1000
`define HOLD_SETUP_NS    20000
`define HOLD_NORM_CYC    ((`HOLD_NORM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_SETUP_CYC   ((`HOLD_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== verilog/touch_pkg.sv ====
/*
  Types shared by the touch controller serial port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package touch_pkg;
   typedef logic [7:0] byte_t;
   // bus engine states
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_HOLD, ST_ACK, ST_TX, ST_MACK
   } state_e;
endpackage
`default_nettype wire

// ==== verilog/touch_controller_i2c_slave_port.sv ====
/*
  Two-wire slave port of a touch controller with its register array.
  Assumes scl and sda arrive asynchronously and are wired-and outside;
  setup_mode comes from logic on clk_sys.
*/
// Notes on behaviour
// - in normal mode the seven setup registers refuse writes
// - in setup mode every register but read-only ones is writable, the protected one only after the pass code
// - setup mode stretches longer; command 0x0A at 0xA0 shortens it
// - first byte is address plus direction; only own address answered
// - direction bit zero means write, one means read
// - slave address lives in a register, no strap pins
// - after each received byte it answers scl is held low until processed; a foreign address byte is not held
// - write: address, pointer, data bytes each acked, stop
// - read: set pointer, restart with read, master naks last
// - registers are read-write, read-only or pass-code protected
`timescale 1ns/1ps
`default_nettype none
`include "touch_cfg.svh"
module touch_controller_i2c_slave_port #(
   parameter logic [6:0]       ADDR_DEFAULT = 7'h01,
   parameter touch_pkg::byte_t ID_VALUE     = 8'h00 // arbitrary value
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic scl_in,
   input  wire logic sda_in,
   input  wire logic setup_mode,
   output logic      scl_out,
   output logic      scl_oe_n,
   output logic      sda_out,
   output logic      sda_oe_n,
   output logic      scan_off,
   output logic [6:0] slave_addr
);
   import touch_pkg::*;
   // =====================================================================
   // parameter check
   if (ADDR_DEFAULT == 7'h00) begin : g_bad_addr
      $error("general call address cannot be the slave address");
   end
   // =====================================================================
   // declarations
   logic   scl_m_r, scl_q_r, scl_d_r, sda_m_r, sda_q_r, sda_d_r;
   logic   scl_rise, scl_fall, start_c, stop_c;
   state_e st_r;
   logic [3:0]  bit_r;
   byte_t       sh_r;
   byte_t       ptr_r;
   byte_t       rd_byte_c;
   byte_t       mem_r [0:255];
   logic        first_r, ptr_phase_r, rd_dir_r, armed_r;
   logic [15:0] cnt_r;
   logic [15:0] hold_cyc_c;
   logic        wr_go_c, arm_c, wr_ok_c, hold_c;
   localparam int NORM_HOLD_MAX = `HOLD_NORM_CYC + 2; // sync slack
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // register classes
   function automatic logic is_setup_only(input byte_t a);
      return a == `REG_CS_ENABLE || a == `REG_DIG_ENABLE ||
             a == `REG_STRONG_DM || a == `REG_SETL_TIME ||
             a == `REG_OTH_SET || a == `REG_SCAN_POS_0 ||
             a == `REG_SCAN_POS_1;
   endfunction
   function automatic logic is_read_only(input byte_t a);
      return a == `REG_DEVICE_ID;
   endfunction
   function automatic logic is_protected(input byte_t a);
      return a == `REG_SLAVE_ADDR;
   endfunction
   function automatic byte_t factory_default_value(input byte_t a);
      case (a)
         `REG_ADDR_LOCK:  return `DEF_ADDR_LOCK;
         `REG_SLAVE_ADDR: return {1'b0, ADDR_DEFAULT};
         default:         return 8'h00;
      endcase
   endfunction
   // =====================================================================
   // pin synchronisers; third stage only feeds edge detection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scl_m_r <= 1'b1;
         scl_q_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_q_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_m_r <= scl_in;
         scl_q_r <= scl_m_r;
         scl_d_r <= scl_q_r;
         sda_m_r <= sda_in;
         sda_q_r <= sda_m_r;
         sda_d_r <= sda_q_r;
      end
   end

   // line conditions seen after synchronisation
   assign scl_rise = scl_q_r & ~scl_d_r;
   assign scl_fall = ~scl_q_r & scl_d_r;
   assign start_c  = scl_q_r & scl_d_r & sda_d_r & ~sda_q_r;
   assign stop_c   = scl_q_r & scl_d_r & ~sda_d_r & sda_q_r;
   // =====================================================================
   // byte processing decisions at the end of a stretch
   assign hold_c     = (st_r == ST_HOLD);
   // scanning off brings setup-mode stretch back to the short figure
   assign hold_cyc_c = (setup_mode && !scan_off) ?
                       16'(`HOLD_SETUP_CYC) : 16'(`HOLD_NORM_CYC);
   assign wr_go_c    = hold_c && cnt_r == 16'h0000 && !first_r &&
                       !ptr_phase_r;
   // pass code to a protected register arms the following byte
   assign arm_c      = wr_go_c && is_protected(ptr_r) && !armed_r &&
                       sh_r == `PASS_CODE;
   assign wr_ok_c    = wr_go_c && !is_read_only(ptr_r) &&
                       !(is_setup_only(ptr_r) && !setup_mode) &&
                       !(is_protected(ptr_r) && !armed_r);
   assign rd_byte_c  = (ptr_r == `REG_DEVICE_ID) ? ID_VALUE : mem_r[ptr_r];
   // =====================================================================
   // bus engine: receive, stretch, acknowledge, transmit
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r        <= ST_IDLE;
         bit_r       <= 4'h0;
         sh_r        <= 8'h00;
         ptr_r       <= 8'h00;
         first_r     <= 1'b0;
         ptr_phase_r <= 1'b0;
         rd_dir_r    <= 1'b0;
         armed_r     <= 1'b0;
         cnt_r       <= 16'h0000;
         scl_oe_n    <= 1'b1;
         sda_oe_n    <= 1'b1;
         scl_out     <= 1'b0;
         sda_out     <= 1'b0;
      end else if (start_c) begin
         st_r     <= ST_RX;
         bit_r    <= 4'h0;
         first_r  <= 1'b1;
         armed_r  <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else if (stop_c) begin
         st_r     <= ST_IDLE;
         armed_r  <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         case (st_r)
            ST_RX: begin
               if (scl_rise) begin
                  sh_r  <= {sh_r[6:0], sda_q_r};
                  bit_r <= bit_r + 4'h1;
               end else if (scl_fall && bit_r == 4'h8) begin
                  if (first_r && sh_r[7:1] != slave_addr) begin
                     st_r <= ST_IDLE;
                  end else begin
                     // ack is set up now, well before scl is let go
                     st_r     <= ST_HOLD;
                     scl_oe_n <= 1'b0;
                     sda_oe_n <= 1'b0;
                     cnt_r    <= hold_cyc_c;
                  end
               end
            end
            ST_HOLD: begin
               if (cnt_r != 16'h0000) begin
                  cnt_r <= cnt_r - 16'h0001;
               end else begin
                  st_r     <= ST_ACK;
                  scl_oe_n <= 1'b1;
                  armed_r  <= arm_c;
                  if (first_r) begin
                     first_r     <= 1'b0;
                     rd_dir_r    <= sh_r[0];
                     ptr_phase_r <= ~sh_r[0];
                  end else if (ptr_phase_r) begin
                     ptr_r       <= sh_r;
                     ptr_phase_r <= 1'b0;
                  end else if (!arm_c) begin
                     ptr_r <= ptr_r + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (rd_dir_r) begin
                     st_r     <= ST_TX;
                     sh_r     <= rd_byte_c;
                     sda_oe_n <= rd_byte_c[7];
                     bit_r    <= 4'h1;
                  end else begin
                     st_r     <= ST_RX;
                     sda_oe_n <= 1'b1;
                     bit_r    <= 4'h0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_r == 4'h8) begin
                     st_r     <= ST_MACK;
                     sda_oe_n <= 1'b1;
                  end else begin
                     sda_oe_n <= sh_r[6];
                     sh_r     <= {sh_r[6:0], 1'b0};
                     bit_r    <= bit_r + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  ptr_r <= ptr_r + 8'h01;
                  bit_r <= 4'h0;
                  if (sda_q_r) begin
                     st_r <= ST_IDLE;
                  end
               end else if (scl_fall && bit_r == 4'h0) begin
                  st_r     <= ST_TX;
                  sh_r     <= rd_byte_c;
                  sda_oe_n <= rd_byte_c[7];
                  bit_r    <= 4'h1;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
   // =====================================================================
   // register array; refused writes never reach it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < 256; i++) begin
            mem_r[i] <= factory_default_value(8'(i));
         end
      end else if (wr_ok_c) begin
         mem_r[ptr_r] <= sh_r;
      end
   end
   // address comes from the protected register, no straps
   assign slave_addr = mem_r[`REG_SLAVE_ADDR][6:0];

   // scan control from the command register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         scan_off <= 1'b0;
      end else if (wr_ok_c && ptr_r == `REG_COMMAND) begin
         if (sh_r == `CMD_SCAN_OFF) begin
            scan_off <= 1'b1;
         end else if (sh_r == `CMD_SCAN_ON) begin
            scan_off <= 1'b0;
         end
      end
   end

   // =====================================================================
   // assertions
   a_setup_only_refused: assert property (
      wr_go_c && is_setup_only(ptr_r) && !setup_mode |-> !wr_ok_c)
      else $error("setup-only register written in normal mode");
   a_setup_write_ok: assert property (wr_go_c && setup_mode &&
      !is_read_only(ptr_r) && !is_protected(ptr_r) |-> wr_ok_c)
      else $error("setup mode refused a writable register");
   a_norm_hold_len: assert property (
      $rose(hold_c) && !setup_mode |-> ##[1:NORM_HOLD_MAX] !hold_c)
      else $error("normal-mode stretch too long");
   a_setup_hold_len: assert property (
      $rose(hold_c) && setup_mode && !scan_off |-> hold_c[*8])
      else $error("setup-mode stretch too short");
   a_addr_match: assert property ($rose(hold_c) && first_r |->
      sh_r[7:1] == slave_addr)
      else $error("foreign address acknowledged");
   a_read_dir: assert property ($rose(st_r == ST_TX) |-> rd_dir_r)
      else $error("transmit without read direction");
   a_scl_held: assert property (
      hold_c |-> !scl_oe_n ##1 (hold_c || scl_oe_n))
      else $error("scl not held through the stretch");
   a_protect_refused: assert property (
      wr_go_c && is_protected(ptr_r) && !armed_r |=> $stable(slave_addr))
      else $error("protected register written without pass code");
   a_ptr_advance: assert property (wr_go_c && !arm_c &&
      !start_c && !stop_c |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer did not advance after data byte");
   a_scan_cmd: assert property (
      wr_ok_c && ptr_r == `REG_COMMAND && sh_r == `CMD_SCAN_OFF |=> scan_off)
      else $error("scan-off command ignored");
endmodule
`default_nettype wire

// ==== bench/i2c_master_model.sv ====
/*
  Behavioural two-wire bus master that drives the touch port bench.
  Assumes the bench resolves both wires with pull-ups into scl_w, sda_w.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   input  wire logic scl_w,
   input  wire logic sda_w,
   output var  logic scl_m,
   output var  logic sda_m
);
   // =================================================================
   // bit timing: four quarters make the 125 ns link clock
   localparam realtime QTR = 31.25;
   realtime t_fall;
   realtime low_t;
   // lines start released so the bus looks idle
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      t_fall = 0;
      low_t = 0;
   end
   // one bit; the low time before the rise shows any stretch
   task automatic bit_xfer(input logic v, output logic s);
      sda_m = v;
      #QTR;
      scl_m = 1'b1;
      wait (scl_w);
      low_t = $realtime - t_fall;
      #QTR;
      s = sda_w;
      #QTR;
      scl_m = 1'b0;
      t_fall = $realtime;
      #QTR;
   endtask
   // start only from a high clock, never over a pending ack
   task automatic start();
      sda_m = 1'b1;
      #QTR;
      scl_m = 1'b1;
      wait (scl_w);
      #(2 * QTR);
      sda_m = 1'b0;
      #(2 * QTR);
      scl_m = 1'b0;
      t_fall = $realtime;
      #QTR;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #QTR;
      scl_m = 1'b1;
      wait (scl_w);
      #(2 * QTR);
      sda_m = 1'b1;
      #(4 * QTR);
   endtask
   // msb first, ack sampled from the wire in the ninth bit
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(b[i], s);
      end
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask
   // master acks each byte and naks the last one
   task automatic read_byte(input logic nak, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(nak, s);
   endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the touch controller serial port.
  Assumes the design files and the bus master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "touch_cfg.svh"
module tb_top;
   import touch_pkg::*;
   localparam logic [6:0] ADR0   = 7'h01;
   localparam byte_t      ID_VAL = 8'h3c; // arbitrary value
   logic       clk_sys, reset, setup_mode, scl_m, sda_m;
   logic       scl_out, scl_oe_n, sda_out, sda_oe_n, scan_off;
   logic [6:0] slave_addr, adr, new_adr;
   int         fails, check_count, hold;
   byte_t      q[$], d[$], keep;
   // wired-and with pull-ups: a released line reads high
   wire        scl_w = scl_m & (scl_oe_n | scl_out);
   wire        sda_w = sda_m & (sda_oe_n | sda_out);

   touch_controller_i2c_slave_port #(
      .ADDR_DEFAULT (ADR0),
      .ID_VALUE     (ID_VAL)
   ) dut_u (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .scl_in     (scl_w),
      .sda_in     (sda_w),
      .setup_mode (setup_mode),
      .scl_out    (scl_out),
      .scl_oe_n   (scl_oe_n),
      .sda_out    (sda_out),
      .sda_oe_n   (sda_oe_n),
      .scan_off   (scan_off),
      .slave_addr (slave_addr)
   );
   i2c_master_model mst_u (
      .scl_w (scl_w),
      .sda_w (sda_w),
      .scl_m (scl_m),
      .sda_m (sda_m)
   );

   // =================================================================
   // checking helpers
   task automatic check(input string nm, input logic [7:0] exp, got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         fails++;
      end
   endtask
   // stretch may end up to ten cycles late for sync and edge delays
   task automatic in_range(input string nm, input int c, input realtime t);
      check_count++;
      if (t < c * 10 || t > c * 10 + 100) begin
         $display("unexpected %s: expected %0d cycles, seen %0.1f ns",
                  nm, c, t);
         fails++;
      end
   endtask
   // stretch per mode; the hold counter runs out one cycle after its figure
   function automatic int stretch_cycles(input logic setup, scan_stop);
      return (setup && !scan_stop) ? `HOLD_SETUP_CYC + 1
                                   : `HOLD_NORM_CYC + 1;
   endfunction
   task automatic wb(input byte_t b, input logic ok);
      logic ak;
      mst_u.write_byte(b, ak);
      check("ack", {7'h00, ok}, {7'h00, ak});
      in_range("stretch", ok ? hold : 0, mst_u.low_t);
   endtask
   task automatic wr(input logic [6:0] a, input byte_t r, input byte_t v[$],
                     input logic ok);
      mst_u.start();
      wb({a, 1'b0}, ok);
      if (ok) begin
         wb(r, 1'b1);
         foreach (v[i]) wb(v[i], 1'b1);
      end
      mst_u.stop();
   endtask
   task automatic rd(input logic [6:0] a, input byte_t r, input int n);
      byte_t none[$];
      byte_t b;
      wr(a, r, none, 1'b1);
      mst_u.start();
      wb({a, 1'b1}, 1'b1);
      d = {};
      for (int i = 0; i < n; i++) begin
         mst_u.read_byte(i == n - 1, b);
         d.push_back(b);
      end
      mst_u.stop();
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // =================================================================
   // clock, watchdog and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // whole run is about 21k cycles, so 1 ms means a hang
   initial begin
      #1000000;
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hd404f309));
      reset = 1'b1;
      setup_mode = 1'b0;
      hold = stretch_cycles(1'b0, 1'b0);
      adr = ADR0;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("address", {1'b0, ADR0}, {1'b0, slave_addr});
      check("scan off", 8'h00, {7'h00, scan_off});
      check("drive low", 8'h00, {6'h00, scl_out, sda_out});
      // foreign address gets neither stretch nor ack
      q = {8'h11};
      wr(adr ^ 7'h40, 8'h4e, q, 1'b0);
      // burst runs into a setup-only register; last byte written is never zero
      q = {byte_t'($urandom), byte_t'($urandom), byte_t'($urandom | 32'h80)};
      wr(adr, 8'h4e, q, 1'b1);
      rd(adr, 8'h4e, 3);
      check("burst0", q[0], d[0]);
      check("burst1", q[1], d[1]);
      check("setup only", 8'h00, d[2]);
      q = {~ID_VAL};
      wr(adr, `REG_DEVICE_ID, q, 1'b1);
      rd(adr, `REG_DEVICE_ID, 1);
      check("read only", ID_VAL, d[0]);
      // setup mode stretches long until scanning is switched off
      @(posedge clk_sys);
      setup_mode <= 1'b1;
      hold = stretch_cycles(1'b1, 1'b0);
      keep = byte_t'($urandom);
      q = {keep};
      wr(adr, `REG_CS_ENABLE, q, 1'b1);
      q = {`CMD_SCAN_OFF};
      wr(adr, `REG_COMMAND, q, 1'b1);
      check("scan off", 8'h01, {7'h00, scan_off});
      hold = stretch_cycles(1'b1, 1'b1);
      rd(adr, `REG_CS_ENABLE, 1);
      check("setup write", keep, d[0]);
      // protected address needs the pass code in the same write
      new_adr = 7'h08 + 7'($urandom % 112);
      if (new_adr == 7'h5a) new_adr = 7'h5b;
      q = {byte_t'({1'b0, new_adr})};
      wr(adr, `REG_SLAVE_ADDR, q, 1'b1);
      check("address", {1'b0, adr}, {1'b0, slave_addr});
      q = {`PASS_CODE, byte_t'({1'b0, new_adr})};
      wr(adr, `REG_SLAVE_ADDR, q, 1'b1);
      check("address", {1'b0, new_adr}, {1'b0, slave_addr});
      wr(adr, 8'h4e, q, 1'b0);
      rd(new_adr, `REG_CS_ENABLE, 1);
      check("new address", keep, d[0]);
      // scanning back on; this write still sees the short stretch
      q = {`CMD_SCAN_ON};
      wr(new_adr, `REG_COMMAND, q, 1'b1);
      check("scan on", 8'h00, {7'h00, scan_off});
      finish_test();
   end
endmodule
`default_nettype wire
